//--- rtl/fwhd_consts.svh
// Constants for the firmware range ID and I/O window decode block.
// Assumes byte-addressed configuration offsets and a 32-bit host address.
`ifndef FWHD_CONSTS_SVH
`define FWHD_CONSTS_SVH

// =====================================================================
// Register offsets (byte addresses in configuration space)
`define FWHD_OFF_ID_MAP_512K 8'he8
`define FWHD_OFF_IO_WIN_TWO 8'hec
`define FWHD_OFF_ID_MAP_1M 8'hee
`define FWHD_OFF_DEC_EN_1M 8'hf0

// =====================================================================
// Reset values
`define FWHD_RST_ID_MAP_512K 32'h00112233
`define FWHD_RST_IO_WIN_TWO 16'h0000
`define FWHD_RST_ID_MAP_1M 16'h4567
`define FWHD_RST_DEC_EN_1M 8'h0f

// =====================================================================
// Field positions and masks
`define FWHD_ID_512K_WMASK 32'h0fffffff
`define FWHD_IO_BASE_MSB 15
`define FWHD_IO_BASE_LSB 4
`define FWHD_IO_EN_BIT 0
`define FWHD_IO_WIN_WMASK 16'hfff1
`define FWHD_DEC_EN_1M_WMASK 8'h0f

// =====================================================================
// Address decode values
`define FWHD_HUB_512K_TAG 9'h1ff
`define FWHD_HUB_1M_TAG 9'h1fe
`define FWHD_LEGACY_TAG 15'h0007
`define FWHD_IO_UPPER_ZERO 16'h0000

`endif

//--- rtl/fwhd_pkg.sv
// Types for the firmware range ID and I/O window decode block.
// Assumes nothing beyond the constants header.
package fwhd_pkg;

  // =====================================================================
  // Claim kinds for a decoded cycle
  typedef enum logic [1:0] {
    FWHD_CLAIM_NONE = 2'b00,
    FWHD_CLAIM_POS = 2'b01,
    FWHD_CLAIM_SUB = 2'b10
  } fwhd_claim_t;

  typedef logic [3:0] fwhd_id_t;

endpackage

//--- rtl/fwhd_dec_if.sv
// Interface carrying register fields to the address decoder and its results back.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface fwhd_dec_if;
  import fwhd_pkg::*;

  logic [31:0] id_map_512k;
  logic [15:0] id_map_1m;
  logic [7:0] en_512k;
  logic [3:0] en_1m;
  logic [11:0] io_base;
  logic io_en;
  logic [31:0] addr;
  logic is_io;
  logic hub_hit;
  fwhd_id_t hub_id;
  logic io_hit;

  // Register side drives fields and the address, reads results
  modport regs (output id_map_512k, id_map_1m, en_512k, en_1m, io_base, io_en, addr, is_io,
                input hub_hit, hub_id, io_hit);
  // Decoder side
  modport dec (input id_map_512k, id_map_1m, en_512k, en_1m, io_base, io_en, addr, is_io,
               output hub_hit, hub_id, io_hit);
endinterface

`default_nettype wire

//--- rtl/fwhd_range_decode.sv
// Combinational address decoder for hub memory ranges and the second I/O window.
// Assumes a stable address and cycle type from the owning module.
`timescale 1ns/100ps
`default_nettype none
`include "fwhd_consts.svh"

module fwhd_range_decode
  import fwhd_pkg::*;
(
  fwhd_dec_if.dec d
);

  // Pick one 4-bit ID field out of a packed map
  function automatic fwhd_id_t fwhd_pick_id(input logic [31:0] map, input logic [2:0] idx);
    fwhd_pick_id = map[{idx, 2'b00} +: 4];
  endfunction

  // =====================================================================
  // 512 KB pairs: FF80_0000..FFFF_FFFF, bit 22 picks upper or lower copy
  wire in_512k = (d.addr[31:23] == `FWHD_HUB_512K_TAG);
  wire [2:0] idx_512k = d.addr[21:19];
  wire in_legacy = (d.addr[31:17] == `FWHD_LEGACY_TAG);
  // Legacy 128 KB region follows the top pair and its fixed zero ID
  wire [2:0] sel_512k = in_legacy ? 3'h7 : idx_512k;
  wire hit_512k = (in_512k | in_legacy) & d.en_512k[sel_512k];

  // 1 MB pairs: FF00_0000..FF7F_FFFF, bit 22 picks upper or lower copy
  wire in_1m = (d.addr[31:23] == `FWHD_HUB_1M_TAG);
  wire [1:0] idx_1m = d.addr[21:20];
  wire hit_1m = in_1m & d.en_1m[idx_1m];

  // Memory cycles only for hub ranges
  assign d.hub_hit = ~d.is_io & (hit_512k | hit_1m);
  assign d.hub_id = hit_1m ? fwhd_pick_id({16'h0000, d.id_map_1m}, {1'b0, idx_1m})
                           : fwhd_pick_id(d.id_map_512k, sel_512k);

  // Second generic window: 16 bytes, upper address lines zero, I/O only
  assign d.io_hit = d.is_io & d.io_en & (d.addr[31:16] == `FWHD_IO_UPPER_ZERO)
                    & (d.addr[15:4] == d.io_base);

endmodule // fwhd_range_decode

`default_nettype wire

//--- rtl/fwhd_top.sv
// Firmware range ID and second I/O window decode: configuration registers and claim logic.
// Assumes configuration accesses and host cycles come from logic on clk.
//
// Operation
// - Top hub ID field bits 31:28 is read-only zero, covering top pair and legacy.
// - Seven writable 4-bit hub IDs in bits 27:0 for 512 KB pairs.
// - Four writable 4-bit hub IDs select IDs for the 1 MB pairs.
// - Bits 3:0 of the 1 MB enable register gate each 1 MB pair.
// - Enabled 1 MB pairs claim memory cycles and forward them to the hub.
// - Hub range claims are subtractive unless positive decode enable is set; window two claims are always positive.
// - Window two base comes from bits 15:4; upper address bits must be zero.
// - Window two spans 16 bytes from its base.
// - Window two matches I/O cycles only, never memory cycles.
// - Bit 0 enables forwarding of window two I/O cycles to the LPC side.
// - Each 512 KB pair is gated by its own enable bit.
`timescale 1ns/100ps
`default_nettype none
`include "fwhd_consts.svh"

module fwhd_top
  import fwhd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic [7:0] range_512k_enable,
  input wire logic positive_decode_enable,
  input wire logic req_valid,
  input wire logic req_io,
  input wire logic [31:0] req_addr,
  output logic claim_positive,
  output logic claim_subtractive,
  output logic fwd_firmware_hub,
  output logic fwd_lpc_io,
  output logic [3:0] hub_id_select
);

  // Merge write data into a register under its byte enables and writable mask
  function automatic logic [31:0] fwhd_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    fwhd_merge = (old_v & ~m) | (new_v & m);
  endfunction

  // =====================================================================
  // Register state
  logic [31:0] id_map_512k_q;
  logic [15:0] io_win_two_q;
  logic [15:0] id_map_1m_q;
  logic [7:0] dec_en_1m_q;
  logic [31:0] cfg_rdata_q;
  fwhd_claim_t claim_q;
  logic fwd_hub_q;
  logic fwd_io_q;
  fwhd_id_t hub_id_q;

  // Dword-aligned address decode; the EC dword holds window two and the 1 MB ID map
  wire [7:0] dw_addr = {cfg_addr[7:2], 2'b00};
  wire sel_e8 = (dw_addr == `FWHD_OFF_ID_MAP_512K);
  wire sel_ec = (dw_addr == `FWHD_OFF_IO_WIN_TWO);
  wire sel_f0 = (dw_addr == `FWHD_OFF_DEC_EN_1M);

  // Next values of the writable registers
  wire [31:0] id_map_512k_d = fwhd_merge(id_map_512k_q, cfg_wdata, cfg_be,
                                         `FWHD_ID_512K_WMASK);
  wire [31:0] ec_dw_d = fwhd_merge({id_map_1m_q, io_win_two_q}, cfg_wdata, cfg_be,
                                   {16'hffff, `FWHD_IO_WIN_WMASK});
  wire [31:0] f0_dw_d = fwhd_merge({24'h000000, dec_en_1m_q}, cfg_wdata, cfg_be,
                                   {24'h000000, `FWHD_DEC_EN_1M_WMASK});

  // Read mux; unmapped offsets and reserved bits read zero
  wire [31:0] rd_mux = sel_e8 ? {4'h0, id_map_512k_q[27:0]} :
                       sel_ec ? {id_map_1m_q, io_win_two_q} :
                       sel_f0 ? {24'h000000, dec_en_1m_q} : 32'h00000000;

  // =====================================================================
  // Configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      id_map_512k_q <= `FWHD_RST_ID_MAP_512K;
      io_win_two_q <= `FWHD_RST_IO_WIN_TWO;
      id_map_1m_q <= `FWHD_RST_ID_MAP_1M;
      dec_en_1m_q <= `FWHD_RST_DEC_EN_1M;
    end else if (cfg_wr) begin
      if (sel_e8) begin
        id_map_512k_q <= id_map_512k_d;
      end
      if (sel_ec) begin
        io_win_two_q <= ec_dw_d[15:0];
        id_map_1m_q <= ec_dw_d[31:16];
      end
      if (sel_f0) begin
        dec_en_1m_q <= f0_dw_d[7:0];
      end
    end
  end

  // Registered read data, valid the cycle after cfg_rd
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rdata_q <= 32'h00000000;
    end else if (cfg_rd) begin
      cfg_rdata_q <= rd_mux;
    end
  end

  // =====================================================================
  // Address decoder
  fwhd_dec_if dif ();

  assign dif.id_map_512k = {4'h0, id_map_512k_q[27:0]};
  assign dif.id_map_1m = id_map_1m_q;
  assign dif.en_512k = range_512k_enable;
  assign dif.en_1m = dec_en_1m_q[3:0];
  assign dif.io_base = io_win_two_q[`FWHD_IO_BASE_MSB:`FWHD_IO_BASE_LSB];
  assign dif.io_en = io_win_two_q[`FWHD_IO_EN_BIT];
  assign dif.addr = req_addr;
  assign dif.is_io = req_io;

  fwhd_range_decode u_dec (
    .d (dif.dec)
  );

  // Claim kind: hub ranges subtractive unless positive decode is on; window two positive
  wire hub_go = req_valid & dif.hub_hit;
  wire io_go = req_valid & dif.io_hit;
  // Cast back to the claim type, since a conditional yields a plain vector
  wire fwhd_claim_t claim_d = fwhd_claim_t'(io_go ? FWHD_CLAIM_POS :
                                            hub_go ? (positive_decode_enable ? FWHD_CLAIM_POS
                                                                             : FWHD_CLAIM_SUB) :
                                            FWHD_CLAIM_NONE);

  // =====================================================================
  // Claim and forward outputs, one-cycle pulses a cycle after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      claim_q <= FWHD_CLAIM_NONE;
      fwd_hub_q <= 1'b0;
      fwd_io_q <= 1'b0;
      hub_id_q <= 4'h0;
    end else begin
      claim_q <= claim_d;
      fwd_hub_q <= hub_go;
      fwd_io_q <= io_go;
      if (hub_go) begin
        hub_id_q <= dif.hub_id;
      end
    end
  end

  assign cfg_rdata = cfg_rdata_q;
  assign claim_positive = (claim_q == FWHD_CLAIM_POS);
  assign claim_subtractive = (claim_q == FWHD_CLAIM_SUB);
  assign fwd_firmware_hub = fwd_hub_q;
  assign fwd_lpc_io = fwd_io_q;
  assign hub_id_select = hub_id_q;

endmodule // fwhd_top

`default_nettype wire

//--- rtl/fwhd_unused_placeholder_never.sv
// Intentionally empty: holds no logic.
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- test/fwhd_hub_model.sv
// Firmware hub on the far side: answers forwarded cycles that carry its ID.
// Assumes it sees the forward pulse and ID of fwhd_top on clk.
`timescale 1ns/100ps
`default_nettype none
module fwhd_hub_model #(
  parameter logic [3:0] MY_ID = 4'h8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic fwd_firmware_hub,
  input wire logic [3:0] hub_id_select,
  output logic [7:0] hits_q
);
  // Count cycles that select this hub only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hits_q <= 8'h00;
    end else if (fwd_firmware_hub && hub_id_select == MY_ID) begin
      hits_q <= hits_q + 8'h01;
    end
  end
endmodule // fwhd_hub_model
`default_nettype wire

//--- test/fwhd_chk_checker.sv
// Timing checks on the claim and forward outputs of fwhd_top.
// Assumes binding to fwhd_top; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module fwhd_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic positive_decode_enable,
  input wire logic [7:0] range_512k_enable,
  input wire logic req_valid,
  input wire logic req_io,
  input wire logic [31:0] req_addr,
  input wire logic claim_positive,
  input wire logic claim_subtractive,
  input wire logic fwd_firmware_hub,
  input wire logic fwd_lpc_io,
  input wire logic [3:0] hub_id_select
);
  // =====================================================
  // Clocking and request shapes
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_off_512k;
    req_valid && !req_io && req_addr[31:23] == 9'h1ff && !range_512k_enable[req_addr[21:19]];
  endsequence
  sequence s_top_hit;
    req_valid && !req_io && req_addr[31:19] == 13'h1fff ##1 fwd_firmware_hub;
  endsequence
  // =====================================================
  // Properties
  property p_io_only;
    fwd_lpc_io |-> $past(req_valid && req_io) && claim_positive;
  endproperty
  a_io_only: assert property (p_io_only) else $error("window forward without io cycle");
  property p_mem_only;
    fwd_firmware_hub |-> $past(req_valid && !req_io);
  endproperty
  a_mem_only: assert property (p_mem_only) else $error("hub forward without memory cycle");
  property p_quiet;
    !req_valid |=> !(claim_positive || claim_subtractive || fwd_firmware_hub || fwd_lpc_io);
  endproperty
  a_quiet: assert property (p_quiet) else $error("pulse without request");
  property p_id_hold;
    !fwd_firmware_hub |-> $stable(hub_id_select);
  endproperty
  a_id_hold: assert property (p_id_hold) else $error("hub id moved without forward");
  property p_win_upper;
    fwd_lpc_io |-> $past(req_addr[31:16]) == 16'h0000;
  endproperty
  a_win_upper: assert property (p_win_upper) else $error("window hit with upper bits set");
  property p_pos;
    fwd_firmware_hub && $past(positive_decode_enable) |-> claim_positive && !claim_subtractive;
  endproperty
  a_pos: assert property (p_pos) else $error("positive claim missing");
  property p_sub;
    fwd_firmware_hub && !$past(positive_decode_enable) |-> claim_subtractive && !claim_positive;
  endproperty
  a_sub: assert property (p_sub) else $error("subtractive claim missing");
  property p_gate;
    s_off_512k |=> !fwd_firmware_hub;
  endproperty
  a_gate: assert property (p_gate) else $error("disabled pair forwarded");
  property p_top_id;
    s_top_hit |-> hub_id_select == 4'h0;
  endproperty
  a_top_id: assert property (p_top_id) else $error("top range id not zero");
endmodule // fwhd_chk
bind fwhd_top fwhd_chk chk_u (.*);
`default_nettype wire

//--- test/fwhd_tb_top.sv
// Self-checking bench for fwhd_top: registers, hub ranges, window two.
// Assumes the design files under rtl and the hub model.
`timescale 1ns/100ps
`default_nettype none
module fwhd_tb_top;
  logic clk, rst, cfg_wr, cfg_rd, positive_decode_enable, req_valid, req_io;
  logic claim_positive, claim_subtractive, fwd_firmware_hub, fwd_lpc_io;
  logic [7:0] cfg_addr, range_512k_enable, hits_q;
  logic [3:0] cfg_be, hub_id_select;
  logic [31:0] cfg_wdata, cfg_rdata, req_addr, r;
  int n_fail, n_checks, cyc;
  fwhd_top dut_u (
    .clk(clk),
    .rst(rst),
    .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr),
    .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata),
    .range_512k_enable(range_512k_enable),
    .positive_decode_enable(positive_decode_enable),
    .req_valid(req_valid),
    .req_io(req_io),
    .req_addr(req_addr),
    .claim_positive(claim_positive),
    .claim_subtractive(claim_subtractive),
    .fwd_firmware_hub(fwd_firmware_hub),
    .fwd_lpc_io(fwd_lpc_io),
    .hub_id_select(hub_id_select)
  );
  fwhd_hub_model hub_u (.clk(clk), .rst(rst), .fwd_firmware_hub(fwd_firmware_hub),
    .hub_id_select(hub_id_select), .hits_q(hits_q));
  // =====================================================
  // Clock and hang limit
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      wrap_up();
    end
  end
  // =====================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1 r = cfg_rdata;
  endtask
  // Result packs claim_pos, claim_sub, hub forward, io forward, hub id
  task automatic req(input logic io, input logic [31:0] a);
    @(posedge clk);
    req_valid <= 1'b1;
    req_io <= io;
    req_addr <= a;
    @(posedge clk);
    req_valid <= 1'b0;
    #1 r = {24'h0, claim_positive, claim_subtractive, fwd_firmware_hub, fwd_lpc_io, hub_id_select};
  endtask
  task automatic wrap_up();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // =====================================================
  // Scenarios
  task automatic t_regs();
    rd(8'he8);
    check(r, 32'h00112233);
    rd(8'hec);
    check(r, 32'h45670000);
    rd(8'hf0);
    check(r, 32'h0000000f);
    wr(8'he8, 4'hf, 32'h12345678);
    rd(8'he8);
    check(r, 32'h02345678);
    rd(8'hf4);
    check(r, 32'h00000000);
    $display("test regs done");
  endtask
  task automatic t_512k();
    req(1'b0, 32'hff800000);
    check(r, 32'h68);
    req(1'b0, 32'hffc80000);
    check(r, 32'h67);
    req(1'b0, 32'hfff80000);
    check(r, 32'h60);
    // Legacy region below one megabyte shares the top pair's zero ID
    req(1'b0, 32'h000e0000);
    check(r, 32'h60);
    @(posedge clk) range_512k_enable <= 8'hfe;
    req(1'b0, 32'hff800000);
    check(r, 32'h00);
    @(posedge clk) range_512k_enable <= 8'h7f;
    req(1'b0, 32'h000f0000);
    check(r, 32'h00);
    @(posedge clk) range_512k_enable <= 8'hff;
    $display("test 512k done");
  endtask
  task automatic t_1m();
    wr(8'hec, 4'hc, 32'h89ab0000);
    req(1'b0, 32'hff400000);
    check(r, 32'h6b);
    @(posedge clk) positive_decode_enable <= 1'b1;
    req(1'b0, 32'hff300000);
    check(r, 32'ha8);
    wr(8'hf0, 4'h1, 32'h0000000e);
    rd(8'hf0);
    check(r, 32'h0000000e);
    req(1'b0, 32'hff000000);
    check(r, 32'h08);
    req(1'b1, 32'hff300000);
    check(r, 32'h08);
    @(posedge clk) positive_decode_enable <= 1'b0;
    check({24'h0, hits_q}, 32'h2);
    $display("test 1m done");
  endtask
  task automatic t_win();
    wr(8'hec, 4'h3, 32'h0000030f);
    rd(8'hec);
    check(r, 32'h89ab0301);
    req(1'b1, 32'h00000305);
    check(r, 32'h98);
    req(1'b1, 32'h00000310);
    check(r, 32'h08);
    req(1'b1, 32'h000002ff);
    check(r, 32'h08);
    req(1'b0, 32'h00000305);
    check(r, 32'h08);
    req(1'b1, 32'h00010305);
    check(r, 32'h08);
    wr(8'hec, 4'h3, 32'h00000300);
    req(1'b1, 32'h00000305);
    check(r, 32'h08);
    $display("test window done");
  endtask
  // Reset, then run every scenario
  initial begin
    rst = 1'b1;
    {cfg_wr, cfg_rd, req_valid, req_io, positive_decode_enable} = 5'h00;
    {cfg_addr, cfg_be, cfg_wdata, req_addr} = 76'h0;
    range_512k_enable = 8'hff;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_512k();
    t_1m();
    t_win();
    wrap_up();
  end
endmodule // fwhd_tb_top
`default_nettype wire
